// *** rtl/uic_id_encoder.sv ***
// Priority encoder that holds the interrupt identification code
`timescale 1ns/1ps
module uic_id_encoder (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire uic_pkg::uic_irq_src_t gated,
    output logic [7:0] irq_id
);
    import uic_pkg::*;

    logic [7:0] next_irq_id;

    // Highest pending enabled source wins
    always_comb begin
        next_irq_id = UIC_ID_NONE;
        if (gated.rx_error) begin
            next_irq_id = UIC_ID_RX_ERROR;
        end else if (gated.rx_data) begin
            next_irq_id = UIC_ID_RX_DATA;
        end else if (gated.rx_timeout) begin
            next_irq_id = UIC_ID_RX_TIMEOUT;
        end else if (gated.tx_empty) begin
            next_irq_id = UIC_ID_TX_EMPTY;
        end else if (gated.modem) begin
            next_irq_id = UIC_ID_MODEM;
        end else if (gated.xoff) begin
            next_irq_id = UIC_ID_XOFF;
        end else if (gated.rts_dtr || gated.cts_dsr) begin
            next_irq_id = UIC_ID_FLOW;
        end
    end

    // Code is registered so a read never sees a glitching value
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_id <= UIC_ID_NONE;
        end else if (clk_en) begin
            irq_id <= next_irq_id;
        end
    end
endmodule

// *** rtl/uic_irq_queue_ctrl.sv ***
// Interrupt enable, identification and queue control for one UART channel
// What this block does
// - Enable bit 0 lets receive-data-ready interrupt through; resets to zero.
// - Enable bit 1 lets transmit-holding-empty interrupt through; resets to zero.
// - Enable bit 2 gates the receive line error interrupt; resets to zero.
// - Enable bit 3 gates the modem status change interrupt; resets to zero.
// - Enable bit 4 gates the Xoff/special character interrupt; resets to zero.
// - Enable bit 5 gates the RTS/DTR change interrupt; resets to zero.
// - Enable bit 6 gates the CTS/DSR change interrupt; resets to zero.
// - Identification bit 0 low while anything enabled pends; resets to C1h.
// - Queue control bit 0 turns FIFO mode on or off; off after reset.
// - Writing one to bit 1 flushes receive FIFO, then clears itself.
// - Writing one to bit 2 flushes transmit FIFO, then clears itself.
// - Enhanced mode bits 5:4 pick transmit trigger 16, 32, 64 or 112.
// - Normal mode bits 7:6 pick receive trigger 1, 4, 8 or 14.
// - Enhanced mode bits 7:6 pick receive trigger 15, 31, 63 or 111.
`timescale 1ns/1ps
module uic_irq_queue_ctrl (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    input wire logic enhanced_mode,
    input wire logic [7:0] rx_fill,
    input wire uic_pkg::uic_irq_src_t events,
    output logic irq_active,
    output logic [7:0] irq_id,
    output logic fifo_enable,
    output logic rx_flush,
    output logic tx_flush,
    output logic [7:0] tx_trigger_level,
    output logic [7:0] rx_trigger_level,
    output logic rx_data_cond
);
    import uic_pkg::*;

    logic [7:0] irq_enable;
    logic [1:0] tx_trig_field;
    logic [1:0] rx_trig_field;
    logic [7:0] next_irq_enable;
    logic next_fifo_enable;
    logic next_rx_flush;
    logic next_tx_flush;
    logic [1:0] next_tx_trig_field;
    logic [1:0] next_rx_trig_field;
    logic [7:0] next_tx_trigger_level;
    logic [7:0] next_rx_trigger_level;
    logic [7:0] next_reg_rdata;
    logic next_reg_rd_valid;
    logic wr_enable_reg;
    logic wr_queue_ctrl;
    uic_irq_src_t src;
    uic_irq_src_t gated;

    // Address match shared by the write and read decode
    function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
        hit = (addr == ofs);
    endfunction

    assign wr_enable_reg = reg_wr_en && hit(reg_addr, UIC_OFS_IRQ_ENABLE);
    assign wr_queue_ctrl = reg_wr_en && hit(reg_addr, UIC_OFS_QUEUE_CTRL);

    // Register writes; flush bits drop on the next enabled cycle
    always_comb begin
        next_irq_enable = irq_enable;
        next_fifo_enable = fifo_enable;
        next_rx_flush = 1'b0; // self-clearing after one cycle
        next_tx_flush = 1'b0;
        next_tx_trig_field = tx_trig_field;
        next_rx_trig_field = rx_trig_field;
        if (wr_enable_reg) begin
            next_irq_enable = {1'b0, reg_wdata[6:0]};
        end
        if (wr_queue_ctrl) begin
            next_fifo_enable = reg_wdata[UIC_QC_FIFO_EN];
            next_rx_flush = reg_wdata[UIC_QC_RX_FLUSH]; // zero does nothing
            next_tx_flush = reg_wdata[UIC_QC_TX_FLUSH];
            next_tx_trig_field = reg_wdata[UIC_QC_TX_TRIG +: 2];
            next_rx_trig_field = reg_wdata[UIC_QC_RX_TRIG +: 2];
        end
    end

    // Trigger decode differs between normal and enhanced mode
    always_comb begin
        case (tx_trig_field)
            2'h0: next_tx_trigger_level = UIC_TX_TRIG_0;
            2'h1: next_tx_trigger_level = UIC_TX_TRIG_1;
            2'h2: next_tx_trigger_level = UIC_TX_TRIG_2;
            default: next_tx_trigger_level = UIC_TX_TRIG_3;
        endcase
        // Transmit trigger has no meaning outside enhanced mode: empty only
        if (!enhanced_mode) begin
            next_tx_trigger_level = UIC_TX_TRIG_PLAIN;
        end
        case ({enhanced_mode, rx_trig_field})
            3'h0: next_rx_trigger_level = UIC_RX_TRIG_N0;
            3'h1: next_rx_trigger_level = UIC_RX_TRIG_N1;
            3'h2: next_rx_trigger_level = UIC_RX_TRIG_N2;
            3'h3: next_rx_trigger_level = UIC_RX_TRIG_N3;
            3'h4: next_rx_trigger_level = UIC_RX_TRIG_E0;
            3'h5: next_rx_trigger_level = UIC_RX_TRIG_E1;
            3'h6: next_rx_trigger_level = UIC_RX_TRIG_E2;
            default: next_rx_trigger_level = UIC_RX_TRIG_E3;
        endcase
    end

    // Read mux; one cycle latency, unmapped offsets read zero
    always_comb begin
        next_reg_rd_valid = reg_rd_en;
        next_reg_rdata = 8'h00;
        if (reg_rd_en && hit(reg_addr, UIC_OFS_IRQ_ENABLE)) begin
            next_reg_rdata = irq_enable;
        end else if (reg_rd_en && hit(reg_addr, UIC_OFS_IRQ_ID)) begin
            next_reg_rdata = irq_id;
        end
    end

    // All state freezes while clk_en is low
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_enable <= UIC_IRQ_ENABLE_RST;
            fifo_enable <= 1'b0;
            rx_flush <= 1'b0;
            tx_flush <= 1'b0;
            tx_trig_field <= UIC_TRIG_FIELD_RST;
            rx_trig_field <= UIC_TRIG_FIELD_RST;
            tx_trigger_level <= UIC_TX_TRIG_PLAIN;
            rx_trigger_level <= UIC_RX_TRIG_N0;
            reg_rdata <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else if (clk_en) begin
            irq_enable <= next_irq_enable;
            fifo_enable <= next_fifo_enable;
            rx_flush <= next_rx_flush;
            tx_flush <= next_tx_flush;
            tx_trig_field <= next_tx_trig_field;
            rx_trig_field <= next_rx_trig_field;
            tx_trigger_level <= next_tx_trigger_level;
            rx_trigger_level <= next_rx_trigger_level;
            reg_rdata <= next_reg_rdata;
            reg_rd_valid <= next_reg_rd_valid;
        end
    end

    // Without FIFO mode any held character counts as ready
    assign rx_data_cond = fifo_enable ? (rx_fill >= rx_trigger_level) : (rx_fill != 8'h00);

    // Source gating by the enable bits
    always_comb begin
        src = events;
        src.rx_data = rx_data_cond;
        gated.rx_error = src.rx_error && irq_enable[UIC_IE_RX_ERROR];
        gated.rx_data = src.rx_data && irq_enable[UIC_IE_RX_DATA];
        gated.rx_timeout = src.rx_timeout && irq_enable[UIC_IE_RX_DATA];
        gated.tx_empty = src.tx_empty && irq_enable[UIC_IE_TX_EMPTY];
        gated.modem = src.modem && irq_enable[UIC_IE_MODEM];
        gated.xoff = src.xoff && irq_enable[UIC_IE_XOFF];
        gated.rts_dtr = src.rts_dtr && irq_enable[UIC_IE_RTS];
        gated.cts_dsr = src.cts_dsr && irq_enable[UIC_IE_CTS];
    end

    uic_id_encoder u_id (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .gated(gated),
        .irq_id(irq_id)
    );

    assign irq_active = !irq_id[0];

    // Checks on the registered behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_reset_values;
        $past(sys_rst) |-> irq_id == UIC_ID_NONE && irq_enable == 8'h00 && !fifo_enable;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset values");

    property p_none_code;
        clk_en && gated == 8'h00 |=> irq_id == UIC_ID_NONE && !irq_active;
    endproperty
    a_none_code: assert property (p_none_code) else $error("no-pending code wrong");

    property p_error_first;
        clk_en && events.rx_error && irq_enable[UIC_IE_RX_ERROR] |=> irq_id == UIC_ID_RX_ERROR;
    endproperty
    a_error_first: assert property (p_error_first) else $error("error not top priority");

    property p_rx_data_code;
        clk_en && rx_data_cond && irq_enable[UIC_IE_RX_DATA] && !gated.rx_error |=> irq_id == UIC_ID_RX_DATA;
    endproperty
    a_rx_data_code: assert property (p_rx_data_code) else $error("rx data code wrong");

    property p_flow_masked;
        clk_en && events.cts_dsr && !irq_enable[UIC_IE_CTS] && !gated.rts_dtr |=> irq_id != UIC_ID_FLOW;
    endproperty
    a_flow_masked: assert property (p_flow_masked) else $error("masked source raised code");

    property p_fifo_enable;
        clk_en && wr_queue_ctrl |=> fifo_enable == $past(reg_wdata[UIC_QC_FIFO_EN]);
    endproperty
    a_fifo_enable: assert property (p_fifo_enable) else $error("fifo enable not stored");

    property p_rx_flush_pulse;
        clk_en && wr_queue_ctrl && reg_wdata[UIC_QC_RX_FLUSH] ##1 clk_en && !wr_queue_ctrl |-> rx_flush ##1 !rx_flush;
    endproperty
    a_rx_flush_pulse: assert property (p_rx_flush_pulse) else $error("rx flush not one pulse");

    property p_tx_flush_idle;
        clk_en && !wr_queue_ctrl |=> !tx_flush;
    endproperty
    a_tx_flush_idle: assert property (p_tx_flush_idle) else $error("tx flush without write");

    property p_tx_trig_112;
        clk_en && enhanced_mode && tx_trig_field == 2'h3 |=> tx_trigger_level == UIC_TX_TRIG_3;
    endproperty
    a_tx_trig_112: assert property (p_tx_trig_112) else $error("tx trigger not 112");

    property p_rx_trig_14;
        clk_en && !enhanced_mode && rx_trig_field == 2'h3 |=> rx_trigger_level == UIC_RX_TRIG_N3;
    endproperty
    a_rx_trig_14: assert property (p_rx_trig_14) else $error("rx trigger not 14");

    property p_rx_trig_111;
        clk_en && enhanced_mode && rx_trig_field == 2'h3 |=> rx_trigger_level == UIC_RX_TRIG_E3;
    endproperty
    a_rx_trig_111: assert property (p_rx_trig_111) else $error("rx trigger not 111");

    property p_rx_below;
        clk_en && fifo_enable && rx_fill < rx_trigger_level |-> !rx_data_cond ##1 irq_id != UIC_ID_RX_DATA;
    endproperty
    a_rx_below: assert property (p_rx_below) else $error("rx ready below trigger");

    c_error_code: cover property (irq_id == UIC_ID_RX_ERROR);
    c_flow_code: cover property (irq_id == UIC_ID_FLOW);
    c_both_flush: cover property (rx_flush && tx_flush);
    c_enh_trigger: cover property (enhanced_mode && rx_data_cond && fifo_enable);
endmodule

// *** rtl/uic_pkg.sv ***
// Constants and carrier types for the UART interrupt and queue control block
package uic_pkg;
    // Register offsets; identification and queue control share one offset
    localparam logic [4:0] UIC_OFS_IRQ_ENABLE = 5'h01;
    localparam logic [4:0] UIC_OFS_IRQ_ID = 5'h02;
    localparam logic [4:0] UIC_OFS_QUEUE_CTRL = 5'h02;

    // Interrupt enable field positions
    localparam int UIC_IE_RX_DATA = 0;
    localparam int UIC_IE_TX_EMPTY = 1;
    localparam int UIC_IE_RX_ERROR = 2;
    localparam int UIC_IE_MODEM = 3;
    localparam int UIC_IE_XOFF = 4;
    localparam int UIC_IE_RTS = 5;
    localparam int UIC_IE_CTS = 6;

    // Queue control field positions
    localparam int UIC_QC_FIFO_EN = 0;
    localparam int UIC_QC_RX_FLUSH = 1;
    localparam int UIC_QC_TX_FLUSH = 2;
    localparam int UIC_QC_TX_TRIG = 4;
    localparam int UIC_QC_RX_TRIG = 6;

    // Reset values
    localparam logic [7:0] UIC_IRQ_ENABLE_RST = 8'h00;
    localparam logic [1:0] UIC_TRIG_FIELD_RST = 2'h0;

    // Identification codes, highest priority first
    localparam logic [7:0] UIC_ID_RX_ERROR = 8'hC6;
    localparam logic [7:0] UIC_ID_RX_DATA = 8'hC4;
    localparam logic [7:0] UIC_ID_RX_TIMEOUT = 8'hCC;
    localparam logic [7:0] UIC_ID_TX_EMPTY = 8'hC2;
    localparam logic [7:0] UIC_ID_MODEM = 8'hC0;
    localparam logic [7:0] UIC_ID_XOFF = 8'hD0;
    localparam logic [7:0] UIC_ID_FLOW = 8'hE0;
    localparam logic [7:0] UIC_ID_NONE = 8'hC1;

    // Trigger levels in entries
    localparam logic [7:0] UIC_TX_TRIG_0 = 8'h10;
    localparam logic [7:0] UIC_TX_TRIG_1 = 8'h20;
    localparam logic [7:0] UIC_TX_TRIG_2 = 8'h40;
    localparam logic [7:0] UIC_TX_TRIG_3 = 8'h70;
    localparam logic [7:0] UIC_TX_TRIG_PLAIN = 8'h00;
    localparam logic [7:0] UIC_RX_TRIG_N0 = 8'h01;
    localparam logic [7:0] UIC_RX_TRIG_N1 = 8'h04;
    localparam logic [7:0] UIC_RX_TRIG_N2 = 8'h08;
    localparam logic [7:0] UIC_RX_TRIG_N3 = 8'h0E;
    localparam logic [7:0] UIC_RX_TRIG_E0 = 8'h0F;
    localparam logic [7:0] UIC_RX_TRIG_E1 = 8'h1F;
    localparam logic [7:0] UIC_RX_TRIG_E2 = 8'h3F;
    localparam logic [7:0] UIC_RX_TRIG_E3 = 8'h6F;

    // Interrupt sources, one bit each, in priority order from the top
    typedef struct packed {
        logic rx_error;
        logic rx_data;
        logic rx_timeout;
        logic tx_empty;
        logic modem;
        logic xoff;
        logic rts_dtr;
        logic cts_dsr;
    } uic_irq_src_t;
endpackage

// *** sim/testbench.sv ***
// Self-checking bench for the interrupt and queue control block
`timescale 1ns/1ps
module testbench;
    import uic_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic enhanced_mode = 1'b0;
    logic [7:0] rx_fill = 8'h00;
    logic [7:0] ev = 8'h00;
    logic [4:0] reg_addr;
    logic reg_wr_en, reg_rd_en, reg_rd_valid, irq_active, fifo_enable, rx_flush, tx_flush, rx_data_cond;
    logic [7:0] reg_wdata, reg_rdata, irq_id, tx_trigger_level, rx_trigger_level, rd;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    // 4 ns period
    always #2 ref_clk = ~ref_clk;

    uic_host_model uic_host_model_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

    uic_irq_queue_ctrl uic_irq_queue_ctrl_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .enhanced_mode(enhanced_mode), .rx_fill(rx_fill),
        .events(uic_irq_src_t'(ev)), .irq_active(irq_active), .irq_id(irq_id), .fifo_enable(fifo_enable),
        .rx_flush(rx_flush), .tx_flush(tx_flush), .tx_trigger_level(tx_trigger_level),
        .rx_trigger_level(rx_trigger_level), .rx_data_cond(rx_data_cond));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic test_reset();
        check("irq_id", irq_id, 8'hC1);
        check("irq_active", {7'h00, irq_active}, 8'h00);
        check("fifo_enable", {7'h00, fifo_enable}, 8'h00);
        check("rx_trigger", rx_trigger_level, 8'h01);
        uic_host_model_i.read(UIC_OFS_IRQ_ENABLE, rd);
        check("irq_enable", rd, 8'h00);
        uic_host_model_i.read(UIC_OFS_IRQ_ID, rd);
        check("irq_id read", rd, 8'hC1);
        uic_host_model_i.read(5'h05, rd);
        check("unmapped read", rd, 8'h00);
    endtask

    // Each enable alone passes its source; all others set still mask it
    task automatic test_enables();
        logic [7:0] src [7] = '{8'h00, 8'h10, 8'h80, 8'h08, 8'h04, 8'h02, 8'h01};
        logic [7:0] code [7] = '{8'hC4, 8'hC2, 8'hC6, 8'hC0, 8'hD0, 8'hE0, 8'hE0};
        for (int i = 0; i < 7; i++) begin
            ev = src[i];
            rx_fill = (i == 0) ? 8'h01 : 8'h00;
            uic_host_model_i.write(UIC_OFS_IRQ_ENABLE, 8'h01 << i);
            settle(3);
            check("irq_id enabled", irq_id, code[i]);
            check("irq_active", {7'h00, irq_active}, 8'h01);
            uic_host_model_i.write(UIC_OFS_IRQ_ENABLE, 8'h7F & ~(8'h01 << i));
            settle(3);
            check("irq_id masked", irq_id, 8'hC1);
            uic_host_model_i.read(UIC_OFS_IRQ_ENABLE, rd);
            check("irq_enable read", rd, 8'h7F & ~(8'h01 << i));
        end
        // Reserved top bit is not stored
        uic_host_model_i.write(UIC_OFS_IRQ_ENABLE, 8'hFF);
        uic_host_model_i.read(UIC_OFS_IRQ_ENABLE, rd);
        check("irq_enable reserved", rd, 8'h7F);
    endtask

    // All sources up, then removed from the top one at a time
    task automatic test_priority();
        logic [7:0] code [9] = '{8'hC6, 8'hC4, 8'hCC, 8'hC2, 8'hC0, 8'hD0, 8'hE0, 8'hE0, 8'hC1};
        for (int k = 0; k < 9; k++) begin
            ev = 8'hFF >> k;
            rx_fill = (k < 2) ? 8'h01 : 8'h00;
            settle(2);
            check("priority", irq_id, code[k]);
            check("irq_active", {7'h00, irq_active}, {7'h00, k < 8});
        end
    endtask

    task automatic test_queue();
        uic_host_model_i.write(UIC_OFS_QUEUE_CTRL, 8'h03);
        check("fifo_enable", {7'h00, fifo_enable}, 8'h01);
        check("flushes", {6'h00, tx_flush, rx_flush}, 8'h01);
        settle(1);
        check("flushes clear", {6'h00, tx_flush, rx_flush}, 8'h00);
        uic_host_model_i.write(UIC_OFS_QUEUE_CTRL, 8'h05);
        check("flushes", {6'h00, tx_flush, rx_flush}, 8'h02);
        settle(1);
        check("flushes clear", {6'h00, tx_flush, rx_flush}, 8'h00);
        uic_host_model_i.write(UIC_OFS_QUEUE_CTRL, 8'h00);
        check("fifo_enable off", {7'h00, fifo_enable}, 8'h00);
        check("flushes zero", {6'h00, tx_flush, rx_flush}, 8'h00);
        uic_host_model_i.write(UIC_OFS_QUEUE_CTRL, 8'h06);
        check("flushes both", {6'h00, tx_flush, rx_flush}, 8'h03);
        check("fifo_enable stays off", {7'h00, fifo_enable}, 8'h00);
    endtask

    task automatic test_triggers();
        logic [7:0] tx_e [4] = '{8'h10, 8'h20, 8'h40, 8'h70};
        logic [7:0] rx_n [4] = '{8'h01, 8'h04, 8'h08, 8'h0E};
        logic [7:0] rx_e [4] = '{8'h0F, 8'h1F, 8'h3F, 8'h6F};
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 4; c++) begin
                enhanced_mode = m[0];
                uic_host_model_i.write(UIC_OFS_QUEUE_CTRL, {c[1:0], c[1:0], 4'h1});
                settle(2);
                check("tx_trigger", tx_trigger_level, m[0] ? tx_e[c] : 8'h00);
                check("rx_trigger", rx_trigger_level, m[0] ? rx_e[c] : rx_n[c]);
            end
        end
    endtask

    // Fill around a trigger of 8 in normal FIFO mode
    task automatic test_rx_cond();
        logic [7:0] fills [4] = '{8'h07, 8'h08, 8'h09, 8'h07};
        logic want [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        ev = 8'h00;
        enhanced_mode = 1'b0;
        uic_host_model_i.write(UIC_OFS_IRQ_ENABLE, 8'h01);
        uic_host_model_i.write(UIC_OFS_QUEUE_CTRL, 8'h81);
        for (int j = 0; j < 4; j++) begin
            rx_fill = fills[j];
            settle(3);
            check("rx_data_cond", {7'h00, rx_data_cond}, {7'h00, want[j]});
            check("irq_id rx", irq_id, want[j] ? 8'hC4 : 8'hC1);
        end
        // Same field in enhanced mode selects a trigger of 63
        enhanced_mode = 1'b1;
        rx_fill = 8'h3E;
        settle(3);
        check("rx_data_cond enh", {7'h00, rx_data_cond}, 8'h00);
        rx_fill = 8'h3F;
        settle(3);
        check("rx_data_cond enh", {7'h00, rx_data_cond}, 8'h01);
        check("irq_id rx enh", irq_id, 8'hC4);
    endtask

    // Low clock enable drops a write and holds the code; mid-run reset restores defaults
    task automatic test_freeze_reset();
        rx_fill = 8'h00;
        uic_host_model_i.write(UIC_OFS_IRQ_ENABLE, 8'h15);
        clk_en = 1'b0;
        ev = 8'h80;
        uic_host_model_i.write(UIC_OFS_IRQ_ENABLE, 8'h2A);
        settle(2);
        check("irq_id frozen", irq_id, 8'hC1);
        clk_en = 1'b1;
        uic_host_model_i.read(UIC_OFS_IRQ_ENABLE, rd);
        check("frozen write", rd, 8'h15);
        check("irq_id error", irq_id, 8'hC6);
        sys_rst = 1'b1;
        settle(2);
        sys_rst = 1'b0;
        check("irq_id reset", irq_id, 8'hC1);
        check("fifo_enable reset", {7'h00, fifo_enable}, 8'h00);
        check("tx_trigger reset", tx_trigger_level, 8'h00);
        check("rx_trigger reset", rx_trigger_level, 8'h01);
        uic_host_model_i.read(UIC_OFS_IRQ_ENABLE, rd);
        check("irq_enable reset", rd, 8'h00);
        check("irq_id masked after reset", irq_id, 8'hC1);
        ev = 8'h00;
    endtask

    // Reset for two cycles, then the scenarios in turn
    initial begin
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        test_reset();
        test_enables();
        test_priority();
        test_queue();
        test_triggers();
        test_rx_cond();
        test_freeze_reset();
        complete_run();
    end
endmodule

// *** sim/uic_host_model.sv ***
// Host-side model issuing register reads and writes to the block
`timescale 1ns/1ps
module uic_host_model (
    input wire logic ref_clk,
    output logic [4:0] reg_addr,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid
);
    // Idle bus at time zero
    initial begin
        reg_addr = 5'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_wdata = 8'h00;
    end

    // One-cycle write strobe, changed only on falling edges
    task automatic write(input logic [4:0] addr, input logic [7:0] data);
        @(negedge ref_clk);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr_en = 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        reg_wr_en = 1'b0;
        // Released lines flip so stale data never looks live
        reg_wdata = ~data;
        reg_addr = ~addr;
    endtask

    // Read answer is taken one cycle after the strobe, unknown if no valid
    task automatic read(input logic [4:0] addr, output logic [7:0] data);
        @(negedge ref_clk);
        reg_addr = addr;
        reg_rd_en = 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        reg_rd_en = 1'b0;
        reg_addr = ~addr;
        data = (reg_rd_valid === 1'b1) ? reg_rdata : 8'hXX;
    endtask
endmodule
